//--- sld_pkg.sv
// Purpose: shared constants and carriers for the serial LED sink driver
// Assumes: system clock of 40 MHz, shift clock sampled from a pin
// Notes:   widths and counts are used by the core and its FIFO
package sld_pkg;

	// ----------------------------------------------------------------
	// sizes and timing
	// ----------------------------------------------------------------
	localparam int unsigned STAGES        = 16;
	localparam int unsigned FIFO_DEPTH    = 4;
	localparam int unsigned SYNC_STAGES   = 2;
	localparam int unsigned CLK_PERIOD_NS = 25;
	// least latch pulse width; rounds up to whole cycles, at least one
	localparam int unsigned LATCH_MIN_NS  = 50;
	localparam int unsigned LATCH_MIN_CYC =
		((LATCH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
		((LATCH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] SHIFT_RST = 16'h0000;
	localparam logic [15:0] HOLD_RST  = 16'h0000;
	localparam logic        CASC_RST  = 1'h0;

	// control levels after the pin synchronisers
	typedef struct packed {
		logic shift_clk;
		logic serial_bit;
		logic latch;
		logic drive_enable_n;
		logic clear_n;
		logic uv_fault;
	} sld_ctrl_t;

	// one shifted sample carried through the FIFO
	typedef struct packed {
		logic serial_bit;
	} sld_beat_t;

endpackage

//--- sld_fifo.sv
// Purpose: small valid/ready FIFO between the pin sampler and the shift chain
// Assumes: one clock, synchronous active-low reset
// Notes:   full and empty come from an occupancy count
`timescale 1ns/1ps
module sld_fifo #(
	parameter int unsigned WIDTH = 1,
	parameter int unsigned DEPTH = 4
) (
	// clock and reset
	input  wire logic             sys_clk_i,
	input  wire logic             rst_b_i,
	// filling side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// draining side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	logic             push;
	logic             pop;

	// ----------------------------------------------------------------
	// handshakes
	// ----------------------------------------------------------------
	assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
	assign out_valid_o = (count_r != '0);
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign out_data_o  = mem_r[rd_ptr_r];

	// storage; no reset needed, only valid entries are read
	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data_i;
		end
	end

	// pointers wrap at the depth, which need not be a power of two
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
			end
		end
	end

	// occupancy
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			count_r <= '0;
		end else if (push && !pop) begin
			count_r <= count_r + 1'b1;
		end else if (pop && !push) begin
			count_r <= count_r - 1'b1;
		end
	end

endmodule

//--- sld_core.sv
// Purpose: sixteen-stage serial LED sink driver with latch and cascade output
// Assumes: all control pins asynchronous to sys_clk_i, shift clock well below 20 MHz
// Notes:   pin edges found by sampling; sink outputs open-drain, oe high = sinking
`timescale 1ns/1ps
module sld_core #(
	parameter int unsigned STAGES = sld_pkg::STAGES,
	parameter int unsigned DEPTH  = sld_pkg::FIFO_DEPTH
) (
	// clock and reset
	input  wire logic              sys_clk_i,
	input  wire logic              rst_b_i,
	// serial link pins
	input  wire logic              shift_clk_i,
	input  wire logic              serial_bit_in_i,
	input  wire logic              latch_i,
	input  wire logic              drive_enable_n_i,
	input  wire logic              clear_n_i,
	// supply monitor comparator
	input  wire logic              uv_fault_i,
	// cascade output to next device
	output logic                   cascade_bit_out_o,
	// open-drain sinks; sink_out_first is bit 0, sink_out_last bit 15
	output logic [STAGES-1:0]      sink_out_o,
	output logic [STAGES-1:0]      sink_oe_o,
	// back-pressure seen by the sampler
	output logic                   fifo_full_o
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	localparam int unsigned NPIN = $bits(sld_pkg::sld_ctrl_t);

	logic [NPIN-1:0]   meta_r;
	logic [NPIN-1:0]   sync_r;
	sld_pkg::sld_ctrl_t ctl;
	logic              sck_prev_r;
	logic              latch_prev_r;
	logic              sck_rise;
	logic              sck_fall;
	logic              latch_rise;
	logic              in_clear;

	// first flop feeds only the second one
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= {shift_clk_i, serial_bit_in_i, latch_i, drive_enable_n_i, clear_n_i, uv_fault_i};
			sync_r <= meta_r;
		end
	end

	assign ctl = sld_pkg::sld_ctrl_t'(sync_r);

	// edge history of the synchronised shift clock and latch
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			sck_prev_r   <= 1'h0;
			latch_prev_r <= 1'h0;
		end else begin
			sck_prev_r   <= ctl.shift_clk;
			latch_prev_r <= ctl.latch;
		end
	end

	assign sck_rise   = ctl.shift_clk && !sck_prev_r;
	assign sck_fall   = !ctl.shift_clk && sck_prev_r;
	assign latch_rise = ctl.latch && !latch_prev_r;
	assign in_clear   = !rst_b_i || !ctl.clear_n;

	// ----------------------------------------------------------------
	// sampled bits buffered ahead of the shift chain
	// ----------------------------------------------------------------
	sld_pkg::sld_beat_t beat_in;
	sld_pkg::sld_beat_t beat_out;
	logic               fifo_in_ready;
	logic               fifo_out_valid;
	logic               fifo_pop;

	assign beat_in.serial_bit = ctl.serial_bit;
	assign fifo_full_o        = !fifo_in_ready;

	sld_fifo #(
		.WIDTH ($bits(sld_pkg::sld_beat_t)),
		.DEPTH (DEPTH)
	) u_fifo (
		.sys_clk_i   (sys_clk_i),
		.rst_b_i     (rst_b_i && ctl.clear_n),
		.in_valid_i  (sck_rise),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (beat_in),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (fifo_pop),
		.out_data_o  (beat_out)
	);

	// the chain drains one bit a cycle; it stalls only while clearing,
	// and edges that come during clear are dropped, since the FIFO is held in reset then
	assign fifo_pop = fifo_out_valid && !in_clear;

	// ----------------------------------------------------------------
	// shift register
	// ----------------------------------------------------------------
	logic [STAGES-1:0] shift_r;
	logic [STAGES-1:0] shift_nxt;

	always_comb begin
		shift_nxt = shift_r;
		if (fifo_pop) begin
			shift_nxt = {shift_r[STAGES-2:0], beat_out.serial_bit};
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (in_clear) begin
			shift_r <= sld_pkg::SHIFT_RST;
		end else begin
			shift_r <= shift_nxt;
		end
	end

	// ----------------------------------------------------------------
	// cascade output
	// ----------------------------------------------------------------
	logic cascade_r;

	// moving on the falling edge gives the next device a full half period
	always_ff @(posedge sys_clk_i) begin
		if (in_clear) begin
			cascade_r <= sld_pkg::CASC_RST;
		end else if (sck_fall) begin
			cascade_r <= shift_r[STAGES-1];
		end
	end

	assign cascade_bit_out_o = cascade_r;

	// ----------------------------------------------------------------
	// output latch
	// ----------------------------------------------------------------
	logic [STAGES-1:0] hold_r;
	logic [STAGES-1:0] hold_nxt;

	always_comb begin
		hold_nxt = hold_r;
		if (latch_rise || ctl.latch) begin
			hold_nxt = shift_nxt;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (in_clear) begin
			hold_r <= sld_pkg::HOLD_RST;
		end else begin
			hold_r <= hold_nxt;
		end
	end

	// ----------------------------------------------------------------
	// sink drive
	// ----------------------------------------------------------------
	logic [STAGES-1:0] pattern;
	logic              force_off;
	logic [STAGES-1:0] oe_r;

	// stage one true, later stages inverted against the serial input
	assign pattern = {~hold_r[STAGES-1:1], hold_r[0]};

	// synchronised power-up clear is the controller's duty
	assign force_off = in_clear || ctl.drive_enable_n || ctl.uv_fault;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			oe_r <= '0;
		end else begin
			oe_r <= force_off ? '0 : pattern;
		end
	end

	// open drain: the pin only ever sinks low
	assign sink_oe_o  = oe_r;
	assign sink_out_o = '0;

endmodule

//--- sld_core_asserts.sv
// Purpose: pin-level checker for sld_core
// Assumes: pins steady a few cycles around changes
// Notes:   allows the sync plus register pipeline
`timescale 1ns/1ps
module sld_core_asserts #(
	parameter int unsigned STAGES = 16
) (
	// clock, reset and pins
	input wire logic              sys_clk_i,
	input wire logic              rst_b_i,
	input wire logic              shift_clk_i,
	input wire logic              latch_i,
	input wire logic              drive_enable_n_i,
	input wire logic              clear_n_i,
	input wire logic              uv_fault_i,
	// outputs
	input wire logic              cascade_bit_out_o,
	input wire logic [STAGES-1:0] sink_out_o,
	input wire logic [STAGES-1:0] sink_oe_o
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	en_off_a: assert property (drive_enable_n_i[*6] |-> sink_oe_o == '0)
		else $error("sinks on while disabled");
	uv_off_a: assert property (uv_fault_i[*6] |-> sink_oe_o == '0)
		else $error("sinks on during undervoltage");
	clr_off_a: assert property ((!clear_n_i)[*6] |-> sink_oe_o == '0 && !cascade_bit_out_o)
		else $error("outputs on while cleared");
	rst_off_a: assert property ($rose(rst_b_i) |-> sink_oe_o == '0 && !cascade_bit_out_o)
		else $error("outputs on after reset");
	// open drain: the level is always low, only the enable moves
	sink_low_a: assert property (sink_out_o == '0)
		else $error("sink level not low");
	// a rise-driven update would be caught three samples after the rise
	casc_fall_a: assert property ($changed(cascade_bit_out_o) && clear_n_i |-> !$past(shift_clk_i, 3))
		else $error("cascade moved after a rise");
	casc_idle_a: assert property ((!shift_clk_i && clear_n_i)[*8] |-> $stable(cascade_bit_out_o))
		else $error("cascade moved with clock idle");
	hold_a: assert property ((!latch_i && !drive_enable_n_i && !uv_fault_i && clear_n_i)[*8]
		|-> $stable(sink_oe_o))
		else $error("sinks moved while latch held");
endmodule

bind sld_core sld_core_asserts #(.STAGES(STAGES)) u_chk (.sys_clk_i, .rst_b_i, .shift_clk_i, .latch_i,
	.drive_enable_n_i, .clear_n_i, .uv_fault_i, .cascade_bit_out_o, .sink_out_o, .sink_oe_o);

//--- sld_host_model.sv
// Purpose: controller model driving shift clock and serial data
// Assumes: 40 MHz system clock, 200 ns shift period
// Notes:   clock idles low, data driven low after each frame
`timescale 1ns/1ps
module sld_host_model (
	// clock
	input  wire logic sys_clk_i,
	// link pins
	output logic      shift_clk_o,
	output logic      serial_bit_o
);
	initial begin
		shift_clk_o = 1'b0;
		serial_bit_o = 1'b0;
	end
	// one frame, first bit sent ends in the last stage
	task automatic send(input logic [15:0] w);
		@(posedge sys_clk_i);
		for (int i = 15; i >= 0; i--) begin
			serial_bit_o <= w[i];
			repeat (4) @(posedge sys_clk_i);
			shift_clk_o <= 1'b1;
			repeat (4) @(posedge sys_clk_i);
			shift_clk_o <= 1'b0;
		end
		repeat (4) @(posedge sys_clk_i);
		serial_bit_o <= 1'b0;
	endtask
endmodule

//--- sld_core_tb.sv
// Purpose: self-checking bench for sld_core
// Assumes: fixed settle time after each pin change
// Notes:   expected {cascade, sinks} queued by the driver
`timescale 1ns/1ps
module sld_core_tb;
	logic        sys_clk = 1'b0;
	logic        rst_b   = 1'b0;
	logic        latch   = 1'b0;
	logic        en_n    = 1'b1;
	logic        clr_n   = 1'b0;
	logic        uv      = 1'b0;
	wire logic   sck;
	wire logic   sdi;
	logic        casc;
	logic [15:0] oe;
	logic [15:0] sink_lvl;
	logic        full;
	logic [16:0] exp_q[$];
	logic [15:0] w;
	int          n_fail = 0;
	int          n_compared = 0;
	int          seed = 56862;
	event        ev;
	// ----------------------------------------------------------------
	// design and far side
	// ----------------------------------------------------------------
	sld_core DUT (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .shift_clk_i(sck), .serial_bit_in_i(sdi),
		.latch_i(latch), .drive_enable_n_i(en_n), .clear_n_i(clr_n), .uv_fault_i(uv),
		.cascade_bit_out_o(casc), .sink_out_o(sink_lvl), .sink_oe_o(oe), .fifo_full_o(full));
	sld_host_model u_host (.sys_clk_i(sys_clk), .shift_clk_o(sck), .serial_bit_o(sdi));
	initial forever #12.5 sys_clk = ~sys_clk;
	// first stage plain, later stages inverted
	function automatic logic [16:0] pat(input logic c, input logic [15:0] v);
		return {c, ~v[15:1], v[0]};
	endfunction
	task automatic check(input logic [16:0] seen, input logic [16:0] want);
		n_compared++;
		if (seen !== want) begin
			n_fail++;
			$display("[ERR] %0t outputs %h expected %h", $time, seen, want);
		end
	endtask
	task automatic final_report();
		if (n_fail == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// fixed wait covers sync, fifo and output register
	task automatic note(input logic [16:0] v);
		exp_q.push_back(v);
		repeat (10) @(posedge sys_clk);
		#1 -> ev;
		@(posedge sys_clk);
	endtask
	initial forever begin
		@ev;
		check({casc, oe}, exp_q.pop_front());
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		n_fail++;
		final_report();
	end
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge sys_clk);
		rst_b <= 1'b1;
		clr_n <= 1'b1;
		note(17'h00000);
		en_n  <= 1'b0;
		latch <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			w = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : 16'($random(seed));
			u_host.send(w);
			note(pat(w[15], w));
		end
		latch <= 1'b0;
		u_host.send(~w);
		note(pat(~w[15], w));
		latch <= 1'b1;
		note(pat(~w[15], ~w));
		en_n <= 1'b1;
		note({~w[15], 16'h0000});
		en_n <= 1'b0;
		uv   <= 1'b1;
		note({~w[15], 16'h0000});
		uv    <= 1'b0;
		clr_n <= 1'b0;
		note(17'h00000);
		clr_n <= 1'b1;
		w = 16'($random(seed));
		u_host.send(w);
		note(pat(w[15], w));
		// open-drain level stays low, and paced edges never fill the buffer
		#1;
		check({1'b0, sink_lvl}, 17'h00000);
		check({16'h0000, full}, 17'h00000);
		final_report();
	end
endmodule
